// [logic/rsx_params.svh]
`ifndef RSX_PARAMS_SVH
`define RSX_PARAMS_SVH

// ==========================================================================
// Clock and timing
// ==========================================================================
// System clock period in nanoseconds (25 MHz).
`define RSX_CLK_PERIOD_NS 40
// Cycles per microsecond, derived from the clock period.
`define RSX_CLK_MHZ       (1000 / `RSX_CLK_PERIOD_NS)

// ==========================================================================
// Field widths of the frame configuration
// ==========================================================================
`define RSX_EXP_W 24
`define RSX_LP_W  16
`define RSX_H_W   12
`define RSX_C_W   16

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define RSX_OFF_CTRL     8'h00
`define RSX_OFF_EXPOSURE 8'h04
`define RSX_OFF_LINE_PER 8'h08
`define RSX_OFF_HEIGHT   8'h0c
`define RSX_OFF_RO_CONST 8'h10
`define RSX_OFF_STATUS   8'h14
`define RSX_OFF_RO_US    8'h18
`define RSX_OFF_EVENT    8'h1c

// ==========================================================================
// Control register bit positions
// ==========================================================================
`define RSX_CTRL_SIMRST  0
`define RSX_CTRL_SEQ     1
`define RSX_CTRL_GLOBAL  2
`define RSX_CTRL_SWITCH  3
`define RSX_CTRL_ACQTRIG 4
`define RSX_CTRL_FRMTRIG 5
`define RSX_CTRL_CONT    6
`define RSX_CTRL_TWIDTH  7

// ==========================================================================
// Reset values
// ==========================================================================
`define RSX_RST_CTRL     8'h00
`define RSX_RST_EXPOSURE 24'h0003e8
`define RSX_RST_LINE_PER 16'h0190
`define RSX_RST_HEIGHT   12'h400
`define RSX_RST_RO_CONST 16'h0000

`endif

// [logic/rsx_pkg.sv]
`include "rsx_params.svh"

package rsx_pkg;

	// ==================================================================
	// Readout sequencer states
	// ==================================================================
	typedef enum logic [1:0] {
		RSX_RO_IDLE  = 2'b00,
		RSX_RO_LINES = 2'b01,
		RSX_RO_TAIL  = 2'b10
	} rsx_ro_state_t;

	// ==================================================================
	// Frame settings, captured together when a frame starts
	// ==================================================================
	typedef struct packed {
		logic [`RSX_EXP_W-1:0] exposure;
		logic [`RSX_LP_W-1:0]  line_period;
		logic [`RSX_H_W-1:0]   region_height;
		logic [`RSX_C_W-1:0]   readout_constant;
	} rsx_frame_cfg_t;

endpackage

// [logic/rsx_exposure_timing.sv]
`timescale 1ns/1ps
`include "rsx_params.svh"

module rsx_exposure_timing
	import rsx_pkg::*;
#(
	parameter int CLK_MHZ = `RSX_CLK_MHZ
) (
	input  wire logic                clk_sys,
	input  wire logic                reset_n,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                frame_trigger,
	output logic                     exposure_active,
	output logic                     flash_window,
	output logic                     line_reset,
	output logic                     line_reset_all,
	output logic      [`RSX_H_W-1:0] reset_line,
	output logic                     line_readout,
	output logic      [`RSX_H_W-1:0] readout_line,
	output logic                     overtrigger
);

	// Refuse a clock rate that cannot give a microsecond figure.
	if (CLK_MHZ < 1) begin : g_bad_clk
		$error("CLK_MHZ must be at least one");
	end

	// ==================================================================
	// Reset release and trigger synchroniser
	// ==================================================================
	logic                rst_s1_ff;      // First reset release stage.
	logic                rst_n_ff;       // Reset used by the whole block.
	logic [2:0]          trg_sync_ff;    // Trigger pin synchroniser.
	logic                trg_lvl_ff;     // Filtered trigger level.

	// Reset is asserted at once and released through two stages.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff  <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff  <= rst_s1_ff;
		end
	end

	// The level only moves when stages two and three agree, which hides
	// a single metastable sample from the edge detectors below.
	wire trg_agree = trg_sync_ff[1] == trg_sync_ff[2];
	wire nxt_trg   = trg_agree ? trg_sync_ff[2] : trg_lvl_ff;
	wire trg_rise  = nxt_trg & ~trg_lvl_ff;
	wire trg_fall  = ~nxt_trg & trg_lvl_ff;

	// Shift the pin through three flip-flops.
	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			trg_sync_ff <= 3'h0;
			trg_lvl_ff  <= 1'b0;
		end else begin
			trg_sync_ff <= {trg_sync_ff[1:0], frame_trigger};
			trg_lvl_ff  <= nxt_trg;
		end
	end

	// ==================================================================
	// Register file
	// ==================================================================
	logic [7:0]           ctrl_ff;       // Mode and trigger settings.
	logic [`RSX_EXP_W-1:0] exp_cfg_ff;   // Exposure time in cycles.
	logic [`RSX_LP_W-1:0] lp_cfg_ff;     // Line period in cycles.
	logic [`RSX_H_W-1:0]  h_cfg_ff;      // Region height in lines.
	logic [`RSX_C_W-1:0]  c_cfg_ff;      // Readout constant in cycles.
	logic                 ovt_evt_ff;    // Sticky overtrigger flag.
	logic [31:0]          ro_us_ff;      // Readout time in microseconds.
	logic                 ovl_last_ff;   // Last frame ran overlapped.

	// Control bits as named wires.
	wire sim_mode   = ctrl_ff[`RSX_CTRL_SIMRST];
	wire seq_en     = ctrl_ff[`RSX_CTRL_SEQ];
	wire global_sh  = ctrl_ff[`RSX_CTRL_GLOBAL];
	wire switchable = ctrl_ff[`RSX_CTRL_SWITCH];
	wire twidth     = ctrl_ff[`RSX_CTRL_TWIDTH];
	wire free_run   = ~ctrl_ff[`RSX_CTRL_ACQTRIG] &
			~ctrl_ff[`RSX_CTRL_FRMTRIG] & ctrl_ff[`RSX_CTRL_CONT];

	// Overlap needs no sequencer, no simultaneous reset, and free run on a
	// switchable sensor in global mode.
	wire overlap_ok = ~seq_en & ~sim_mode &
			(~(switchable & global_sh) | free_run);

	// Bus phases and address decode.
	wire apb_setup = psel & ~penable;
	wire apb_wr    = psel & penable & pready & pwrite;
	wire hit_ctrl  = paddr == `RSX_OFF_CTRL;
	wire hit_exp   = paddr == `RSX_OFF_EXPOSURE;
	wire hit_lp    = paddr == `RSX_OFF_LINE_PER;
	wire hit_h     = paddr == `RSX_OFF_HEIGHT;
	wire hit_c     = paddr == `RSX_OFF_RO_CONST;
	wire hit_st    = paddr == `RSX_OFF_STATUS;
	wire hit_us    = paddr == `RSX_OFF_RO_US;
	wire hit_evt   = paddr == `RSX_OFF_EVENT;
	wire hit_any   = hit_ctrl | hit_exp | hit_lp | hit_h | hit_c |
			hit_st | hit_us | hit_evt;

	// Readout time that the current settings give, in cycles and in us.
	wire [31:0] ro_cyc = 32'(lp_cfg_ff) * 32'(h_cfg_ff) +
			32'(c_cfg_ff);
	wire [31:0] nxt_ro_us = ro_cyc / 32'(CLK_MHZ);

	// Forward declarations of engine state read by the status word.
	logic          exposing_ff;
	rsx_ro_state_t ro_state_ff;
	logic          ovt_set;
	wire           ro_busy = ro_state_ff != RSX_RO_IDLE;

	// Read data mux; unused bits read as zero.
	wire [31:0] rd_status = {27'h0, ovl_last_ff, overlap_ok, ro_busy,
			flash_window, exposing_ff};
	wire [31:0] nxt_prdata =
			hit_ctrl ? {24'h0, ctrl_ff} :
			hit_exp  ? 32'(exp_cfg_ff) :
			hit_lp   ? 32'(lp_cfg_ff) :
			hit_h    ? 32'(h_cfg_ff) :
			hit_c    ? 32'(c_cfg_ff) :
			hit_st   ? rd_status :
			hit_us   ? ro_us_ff :
			hit_evt  ? {31'h0, ovt_evt_ff} : 32'h0;

	// Answer every access with no wait: ready is raised for the access
	// phase by the setup cycle, so prdata and pslverr are flip-flops too.
	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup & ~hit_any;
			prdata  <= apb_setup & ~pwrite ? nxt_prdata : 32'h0;
		end
	end

	// Writable settings; the overtrigger flag is write one to clear and a
	// new event in the same cycle wins over the clear.
	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			ctrl_ff    <= `RSX_RST_CTRL;
			exp_cfg_ff <= `RSX_RST_EXPOSURE;
			lp_cfg_ff  <= `RSX_RST_LINE_PER;
			h_cfg_ff   <= `RSX_RST_HEIGHT;
			c_cfg_ff   <= `RSX_RST_RO_CONST;
			ovt_evt_ff <= 1'b0;
			ro_us_ff   <= 32'h0;
		end else begin
			if (apb_wr && hit_ctrl)
				ctrl_ff <= pwdata[7:0];
			if (apb_wr && hit_exp)
				exp_cfg_ff <= pwdata[`RSX_EXP_W-1:0];
			if (apb_wr && hit_lp)
				lp_cfg_ff <= pwdata[`RSX_LP_W-1:0];
			if (apb_wr && hit_h)
				h_cfg_ff <= pwdata[`RSX_H_W-1:0];
			if (apb_wr && hit_c)
				c_cfg_ff <= pwdata[`RSX_C_W-1:0];
			ovt_evt_ff <= ovt_set |
					(ovt_evt_ff & ~(apb_wr & hit_evt & pwdata[0]));
			ro_us_ff   <= nxt_ro_us;
		end
	end

	// ==================================================================
	// Frame start and exposure of line one
	// ==================================================================
	rsx_frame_cfg_t        cur_ff;       // Settings of the running frame.
	logic [`RSX_EXP_W-1:0] exp_cnt_ff;   // Cycles of exposure left.
	logic [31:0]           period_ff;    // Cycles since the last start.
	logic [31:0]           runtime_ff;   // Runtime of the last frame.
	logic                  started_ff;   // A frame has run since reset.
	logic                  rst_busy_ff;  // Staggered resets in progress.

	// A start needs line one free, the resets done and, during a
	// readout, overlap allowed. Anything else is an overtrigger.
	wire start = trg_rise & ~exposing_ff & ~rst_busy_ff &
			(~ro_busy | overlap_ok);
	wire start_refused = trg_rise & ~start;

	// Exposure of line one ends on the counter, or on the trigger's
	// falling edge in trigger-width mode.
	wire exp_end = exposing_ff &
			(twidth ? trg_fall : exp_cnt_ff == `RSX_EXP_W'(1));
	// Ending while the previous readout still runs drops this frame.
	wire drop    = exp_end & ro_busy;
	wire ro_go   = exp_end & ~ro_busy;
	assign ovt_set = drop | start_refused;

	// Settings captured at start; zero periods and heights act as one.
	rsx_frame_cfg_t nxt_cfg;
	assign nxt_cfg.exposure = exp_cfg_ff == '0 ?
			`RSX_EXP_W'(1) : exp_cfg_ff;
	assign nxt_cfg.line_period = lp_cfg_ff == '0 ?
			`RSX_LP_W'(1) : lp_cfg_ff;
	assign nxt_cfg.region_height = h_cfg_ff == '0 ?
			`RSX_H_W'(1) : h_cfg_ff;
	assign nxt_cfg.readout_constant = c_cfg_ff;

	wire        nxt_exposing = start | (exposing_ff & ~exp_end);
	wire [31:0] nxt_runtime  = 32'(nxt_cfg.exposure) + ro_cyc;
	wire [31:0] nxt_period   = start ? 32'h1 :
			(&period_ff ? period_ff : period_ff + 32'h1);

	// Line one timing, frame period and overlap bookkeeping.
	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			cur_ff      <= '0;
			exposing_ff <= 1'b0;
			exp_cnt_ff  <= '0;
			period_ff   <= 32'h0;
			runtime_ff  <= 32'h0;
			started_ff  <= 1'b0;
			ovl_last_ff <= 1'b0;
		end else begin
			exposing_ff <= nxt_exposing;
			period_ff   <= nxt_period;
			if (start) begin
				cur_ff      <= nxt_cfg;
				exp_cnt_ff  <= nxt_cfg.exposure;
				runtime_ff  <= nxt_runtime;
				started_ff  <= 1'b1;
				ovl_last_ff <= started_ff &
						(period_ff <= runtime_ff);
			end else if (exposing_ff && exp_cnt_ff != '0) begin
				exp_cnt_ff <= exp_cnt_ff - `RSX_EXP_W'(1);
			end
		end
	end

	// ==================================================================
	// Line reset sequencer
	// ==================================================================
	logic [`RSX_LP_W-1:0] rst_tmr_ff;   // Cycles to the next line reset.
	wire  [`RSX_H_W-1:0]  last_line = nxt_cfg.region_height -
			`RSX_H_W'(1);
	wire  [`RSX_H_W-1:0]  cur_last  = cur_ff.region_height - `RSX_H_W'(1);
	wire                  rst_step  = rst_busy_ff && rst_tmr_ff == '0;
	wire  [`RSX_H_W-1:0]  rst_next  = reset_line + `RSX_H_W'(1);

	// The last line reset opens the staggered flash window; in the
	// simultaneous mode all lines reset at the start itself.
	wire last_rst = (start & (sim_mode | last_line == '0)) |
			(rst_step & rst_next == cur_last);

	// Staggered mode resets line one at start, then one line per period.
	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rst_busy_ff    <= 1'b0;
			rst_tmr_ff     <= '0;
			reset_line     <= '0;
			line_reset     <= 1'b0;
			line_reset_all <= 1'b0;
		end else begin
			line_reset     <= start | rst_step;
			line_reset_all <= start & sim_mode;
			if (start) begin
				reset_line  <= '0;
				rst_busy_ff <= ~sim_mode & last_line != '0;
				rst_tmr_ff  <= nxt_cfg.line_period - `RSX_LP_W'(1);
			end else if (rst_step) begin
				reset_line  <= rst_next;
				rst_busy_ff <= rst_next != cur_last;
				rst_tmr_ff  <= cur_ff.line_period - `RSX_LP_W'(1);
			end else if (rst_busy_ff) begin
				rst_tmr_ff <= rst_tmr_ff - `RSX_LP_W'(1);
			end
		end
	end

	// ==================================================================
	// Flash window and exposure outputs
	// ==================================================================
	// Window opens when every line is exposing and closes with line one;
	// if line one ends first the window never opens. On a global shutter
	// it copies exposure active.
	wire nxt_flash = global_sh ? nxt_exposing :
			(exp_end ? 1'b0 :
			(last_rst & nxt_exposing) | flash_window);

	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			exposure_active <= 1'b0;
			flash_window    <= 1'b0;
			overtrigger     <= 1'b0;
		end else begin
			exposure_active <= nxt_exposing;
			flash_window    <= nxt_flash;
			overtrigger     <= ovt_set;
		end
	end

	// ==================================================================
	// Readout sequencer
	// ==================================================================
	// The readout keeps its own copy of the settings, because an
	// overlapped frame may reload the running settings meanwhile.
	logic [`RSX_LP_W-1:0] ro_lp_ff;     // Line period of this readout.
	logic [`RSX_H_W-1:0]  ro_last_ff;   // Index of the bottom line.
	logic [`RSX_C_W-1:0]  ro_c_ff;      // Constant of this readout.
	logic [`RSX_LP_W-1:0] ro_tmr_ff;    // Cycles left in this line.
	logic [`RSX_C_W-1:0]  ro_tail_ff;   // Cycles left of the constant.
	wire ro_line_end = ro_state_ff == RSX_RO_LINES && ro_tmr_ff == '0;
	wire ro_bottom   = readout_line == ro_last_ff;

	// Each line is read for exactly one line period, then the constant.
	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			ro_state_ff  <= RSX_RO_IDLE;
			ro_lp_ff     <= '0;
			ro_last_ff   <= '0;
			ro_c_ff      <= '0;
			ro_tmr_ff    <= '0;
			ro_tail_ff   <= '0;
			readout_line <= '0;
			line_readout <= 1'b0;
		end else begin
			line_readout <= 1'b0;
			case (ro_state_ff)
			RSX_RO_IDLE: begin
				if (ro_go) begin
					ro_state_ff  <= RSX_RO_LINES;
					ro_lp_ff     <= cur_ff.line_period;
					ro_last_ff   <= cur_last;
					ro_c_ff      <= cur_ff.readout_constant;
					ro_tmr_ff    <= cur_ff.line_period - `RSX_LP_W'(1);
					readout_line <= '0;
					line_readout <= 1'b1;
				end
			end
			RSX_RO_LINES: begin
				if (ro_line_end && ro_bottom) begin
					ro_tail_ff  <= ro_c_ff;
					ro_state_ff <= ro_c_ff == '0 ?
							RSX_RO_IDLE : RSX_RO_TAIL;
				end else if (ro_line_end) begin
					readout_line <= readout_line + `RSX_H_W'(1);
					ro_tmr_ff    <= ro_lp_ff - `RSX_LP_W'(1);
					line_readout <= 1'b1;
				end else begin
					ro_tmr_ff <= ro_tmr_ff - `RSX_LP_W'(1);
				end
			end
			RSX_RO_TAIL: begin
				ro_tail_ff <= ro_tail_ff - `RSX_C_W'(1);
				if (ro_tail_ff == `RSX_C_W'(1))
					ro_state_ff <= RSX_RO_IDLE;
			end
			default: ro_state_ff <= RSX_RO_IDLE;
			endcase
		end
	end

	// ==================================================================
	// Checks
	// ==================================================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n_ff);

	// Helper counters: spacing of readout strobes and readout length.
	logic [31:0] gap_ff;
	logic [31:0] busy_ff;
	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			gap_ff  <= 32'h0;
			busy_ff <= 32'h0;
		end else begin
			gap_ff  <= line_readout ? 32'h1 : gap_ff + 32'h1;
			busy_ff <= ro_busy ? busy_ff + 32'h1 : 32'h0;
		end
	end

	a_simrst_all_lines: assert property (start && sim_mode |=>
			line_reset_all && line_reset)
		else $error("simultaneous reset not issued at start");
	a_exp_active_rise: assert property (start |=>
			exposure_active && !$past(exposure_active))
		else $error("exposure active did not rise at start");
	a_readout_after: assert property (ro_go |=>
			line_readout && readout_line == '0 && ro_busy)
		else $error("readout did not follow exposure end");
	a_line_spacing: assert property (line_readout &&
			readout_line != '0 |-> gap_ff == 32'(ro_lp_ff))
		else $error("readout strobes not one line period apart");
	a_readout_length: assert property ($fell(ro_busy) |->
			$past(busy_ff) + 32'h1 == 32'(ro_lp_ff) *
			(32'(ro_last_ff) + 32'h1) + 32'(ro_c_ff))
		else $error("readout length differs from formula");
	a_simrst_flash: assert property (start && sim_mode &&
			!global_sh |=> flash_window)
		else $error("flash window not open at simultaneous start");
	a_seq_no_overlap: assert property (start |->
			!(seq_en && ro_busy))
		else $error("overlapped start with sequencer enabled");
	a_drop_flags: assert property (drop |=>
			overtrigger && !(line_readout && readout_line == '0))
		else $error("early exposure end not flagged");
	a_global_flash: assert property (global_sh &&
			$stable(global_sh) |-> flash_window == exposure_active)
		else $error("global flash differs from exposure active");
	a_flash_closes: assert property (exp_end |=>
			!flash_window && !exposure_active)
		else $error("flash window open past exposure end");

	c_overlap_start: cover property (start && ro_busy);
	c_overtrigger: cover property (drop);
	c_simrst_frame: cover property (start && sim_mode);
	c_readout_done: cover property ($fell(ro_busy));

endmodule // rsx_exposure_timing

// [verif/rsx_trig_src.sv]
`timescale 1ns/1ps
// ==================================================================
// Trigger source model
// ==================================================================
// Holds the pin high for the requested number of cycles. In
// trigger-width mode that width sets when exposure ends.
module rsx_trig_src (
	input  wire logic        clk_sys,
	input  wire logic        go,
	input  wire logic [15:0] hold,
	output logic             frame_trigger
);
	logic [15:0] left_ff; // Cycles left with the pin high.

	// The pin starts low so that no stray frame starts at power-up.
	initial left_ff = 16'h0000;

	// Load the width on a request, then count it down.
	always @(posedge clk_sys) begin
		if (go) begin
			left_ff <= hold;
		end else if (left_ff != 16'h0000) begin
			left_ff <= left_ff - 16'h0001;
		end
	end

	assign frame_trigger = (left_ff != 16'h0000);
endmodule // rsx_trig_src

// [verif/tb_rsx_exposure_timing.sv]
`timescale 1ns/1ps
`include "rsx_params.svh"
// ==================================================================
// Bench for the exposure and readout sequencer
// ==================================================================
module tb_rsx_exposure_timing;
	import rsx_pkg::*;
	logic        clk_sys = 1'b0;      // System clock.
	logic        reset_n = 1'b0;      // Reset, active low.
	logic        psel = 1'b0;         // Bus select.
	logic        penable = 1'b0;      // Bus access phase.
	logic        pwrite = 1'b0;       // Bus direction.
	logic [7:0]  paddr = 8'h00;       // Bus address.
	logic [31:0] pwdata = 32'h0;      // Bus write data.
	logic [31:0] prdata;              // Bus read data.
	logic        pready, pslverr;     // Bus answer.
	logic        go = 1'b0;           // Trigger request.
	logic [15:0] hold = 16'h0005;     // Trigger width.
	logic        frame_trigger;       // Trigger pin.
	logic        exp_a, fl_w, l_rst, l_all, l_ro, ovt; // Strobes.
	logic [11:0] rst_ln, ro_ln;       // Line indices.
	int          num_errors = 0;      // Mismatches seen.
	int          comparisons = 0;     // Compares made.
	int          n_e, n_f, n_r, n_a, n_o, n_l; // Running counts.
	logic [31:0] rd;                  // Last read value.
	logic        er;                  // Last error flag.

	always #20 clk_sys = ~clk_sys;

	rsx_trig_src u_src (.clk_sys(clk_sys), .go(go), .hold(hold),
		.frame_trigger(frame_trigger));

	rsx_exposure_timing u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.frame_trigger(frame_trigger), .exposure_active(exp_a),
		.flash_window(fl_w), .line_reset(l_rst),
		.line_reset_all(l_all), .reset_line(rst_ln),
		.line_readout(l_ro), .readout_line(ro_ln), .overtrigger(ovt));

	// Count cycles and pulses of each output; pulses last one cycle.
	always @(posedge clk_sys) begin
		n_e <= n_e + int'(exp_a === 1'b1);
		n_f <= n_f + int'(fl_w === 1'b1);
		n_r <= n_r + int'(l_ro === 1'b1);
		n_a <= n_a + int'(l_all === 1'b1);
		n_o <= n_o + int'(ovt === 1'b1);
		n_l <= n_l + int'(l_rst === 1'b1);
	end

	// Compare one value with its expectation.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Print the counts and the verdict, then stop.
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One bus transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (int i = 0; i <= 20; i++) begin
			if (i == 20) begin
				num_errors++;
				tally_and_finish();
			end
			@(posedge clk_sys);
			if (pready === 1'b1) begin
				rd = prdata;
				er = pslverr;
				break;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Run one triggered frame in the given mode and check its counts.
	task automatic frame(input logic [7:0] ctl, input int ef,
		input int al, input int ro);
		int e0, f0, r0, a0, l0;
		apb(1'b1, `RSX_OFF_CTRL, {24'h0, ctl});
		{e0, f0, r0, a0, l0} = {n_e, n_f, n_r, n_a, n_l};
		@(posedge clk_sys);
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (1200) @(posedge clk_sys);
		chk(n_e - e0, 260);
		chk(n_f - f0, ef);
		chk(n_r - r0, ro);
		chk(n_a - a0, al);
		chk(n_l - l0, al == 1 ? 1 : 3);
		$display("frame test ctrl %h done", ctl);
	endtask

	// Two triggers a gap apart; count overtriggers and readout strobes.
	task automatic pair(input logic [7:0] ctl, input int gap,
		input logic [15:0] h1, input logic [15:0] h2,
		input int ov, input int ro);
		int o0, r0;
		apb(1'b1, `RSX_OFF_CTRL, {24'h0, ctl});
		{o0, r0} = {n_o, n_r};
		@(posedge clk_sys);
		hold <= h1;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (gap) @(posedge clk_sys);
		hold <= h2;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (1000) @(posedge clk_sys);
		chk(n_o - o0, ov);
		chk(n_r - r0, ro);
		$display("pair test ctrl %h done", ctl);
	endtask

	initial begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		apb(1'b0, `RSX_OFF_EXPOSURE, 32'h0);
		chk(rd, 32'h3e8);
		apb(1'b0, `RSX_OFF_HEIGHT, 32'h0);
		chk(rd, 32'h400);
		apb(1'b0, 8'h40, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		apb(1'b1, `RSX_OFF_EXPOSURE, 32'd260);
		apb(1'b1, `RSX_OFF_LINE_PER, 32'd100);
		apb(1'b1, `RSX_OFF_HEIGHT, 32'd3);
		apb(1'b1, `RSX_OFF_RO_CONST, 32'd50);
		apb(1'b0, `RSX_OFF_RO_US, 32'h0);
		chk(rd, 32'd14);
		$display("register test done");
		frame(8'h00, 60, 0, 3);
		frame(8'h01, 260, 1, 3);
		frame(8'h04, 260, 0, 3);
		// A second start during readout is refused unless overlap is
		// allowed; an early end in trigger-width mode drops the frame.
		pair(8'h02, 400, 16'h0005, 16'h0005, 1, 3);
		pair(8'h0c, 400, 16'h0005, 16'h0005, 1, 3);
		pair(8'h4c, 400, 16'h0005, 16'h0005, 0, 6);
		apb(1'b0, `RSX_OFF_STATUS, 32'h0);
		chk(rd[4], 1'b1);
		pair(8'h80, 250, 16'd100, 16'd50, 1, 3);
		apb(1'b0, `RSX_OFF_EVENT, 32'h0);
		chk(rd[0], 1'b1);
		apb(1'b1, `RSX_OFF_EVENT, 32'h1);
		apb(1'b0, `RSX_OFF_EVENT, 32'h0);
		chk(rd[0], 1'b0);
		$display("overtrigger test done");
		tally_and_finish();
	end
endmodule // tb_rsx_exposure_timing
